//--- hw/cci_pkg.sv
// Register map, field positions and constants of the capture control inputs
// Notes on behaviour
// - External clamp pin counts only while clamp-enable bit 0x18[4] is one; resets zero.
// - Clamp pin disabled: clamp timed internally, delay then duration after hsync trailing edge.
// - Enabled external clamp level defines the clamp interval, to ground or midscale.
// - Clamp pin sense comes from auto detection or polarity field 0x18[7:6].
// - Active coast holds the clock generator: no hsync tracking, frequency and phase kept.
// - Coast pin sense comes from auto detection or polarity field 0x18[7:6].
// - Coast polarity resets to one.
// - Register 0x03 bit 2 set selects the external clock over the PLL clock.
// - Coast works on the shared pin whatever the external clock selection.
// - Power-down pin combines with 0x1E bit 3; bit 4 selects manual, bit 2 polarity.
// - Slicer threshold in 8 mV steps from 8 mV to 256 mV, default 128 mV.
// - Slicer output is a non-inverted copy of the embedded sync.
// - PLL uses the hsync leading edge, clamp the trailing; hsync sense from auto detection or 0x12[5:4].
package cci_pkg;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CLKSEL = 8'h03;
  localparam logic [7:0] IDX_HSPOL  = 8'h12;
  localparam logic [7:0] IDX_CLAMPC = 8'h18;
  localparam logic [7:0] IDX_PWR    = 8'h1E;
  localparam logic [7:0] IDX_SLICE  = 8'h40;
  localparam logic [7:0] IDX_CLDLY  = 8'h41;
  localparam logic [7:0] IDX_CLDUR  = 8'h42;
  localparam logic [7:0] IDX_STAT   = 8'h43;

  // ---------------------------------------------------------------
  // Field positions, writable masks and reset values
  // ---------------------------------------------------------------
  localparam int EXTERNAL_SAMPLE_CLOCK_BIT = 2;
  localparam int HS_MAN_BIT = 5;
  localparam int HS_POL_BIT = 4;
  localparam int CL_MAN_BIT = 7;
  localparam int CL_POL_BIT = 6;
  localparam int CL_EN_BIT  = 4;
  localparam int PD_MAN_BIT = 4;
  localparam int PD_SW_BIT  = 3;
  localparam int PD_POL_BIT = 2;
  localparam int MID_BIT    = 8;
  localparam logic [7:0] MASK_CLKSEL = 8'h04;
  localparam logic [7:0] MASK_HSPOL  = 8'h30;
  localparam logic [7:0] MASK_CLAMPC = 8'hD0;
  localparam logic [7:0] MASK_PWR    = 8'h1C;
  localparam logic [7:0] RST_CLKSEL  = 8'h00;
  localparam logic [7:0] RST_HSPOL   = 8'h00;
  localparam logic [7:0] RST_CLAMPC  = 8'h40;
  localparam logic [7:0] RST_PWR     = 8'h00;

  // ---------------------------------------------------------------
  // Slicer threshold and clamp timer
  // ---------------------------------------------------------------
  localparam int SLICE_W = 5;
  localparam int STEP_MV = 8;
  localparam int MIN_MV  = 8;
  localparam int MAX_MV  = 256;
  localparam int DEF_MV  = 128;
  localparam logic [SLICE_W-1:0] RST_SLICE = SLICE_W'((DEF_MV - MIN_MV) / STEP_MV);
  localparam int CL_CNT_W = 8;
  localparam logic [CL_CNT_W-1:0] CL_ONE    = 8'h01;
  localparam logic [CL_CNT_W-1:0] RST_CLDLY = 8'h10;
  localparam logic [CL_CNT_W:0]   RST_CLDUR = 9'h010;
  localparam int DET_WIN_W = 8;

  typedef enum logic [2:0] {
    CL_IDLE  = 3'b001,
    CL_DELAY = 3'b010,
    CL_HOLD  = 3'b100
  } cci_clamp_state_type;

  function automatic logic [ADDR_W-1:0] cci_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic cci_hit(input logic [ADDR_W-1:0] a);
    return a == cci_addr(IDX_CLKSEL) || a == cci_addr(IDX_HSPOL) ||
           a == cci_addr(IDX_CLAMPC) || a == cci_addr(IDX_PWR) ||
           a == cci_addr(IDX_SLICE) || a == cci_addr(IDX_CLDLY) ||
           a == cci_addr(IDX_CLDUR) || a == cci_addr(IDX_STAT);
  endfunction
endpackage

//--- hw/cci_pin_cond.sv
// Pin conditioner: two-flop synchroniser, polarity detection and selection
`timescale 1ns/100ps
`default_nettype none
module cci_pin_cond
  import cci_pkg::*;
#(
  parameter int WIN_W = DET_WIN_W
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pin and polarity control
  input  wire logic pin_in,
  input  wire logic manual_sel,
  input  wire logic manual_pol,
  // Conditioned level
  output logic      active,
  output logic      auto_pol
);
  logic             s1_reg;
  logic             s2_reg;
  logic             act_reg;
  logic             act_next;
  logic             pol_reg;
  logic             pol_next;
  logic             pol_use;
  logic [WIN_W-1:0] win_reg;
  logic [WIN_W-1:0] win_next;
  logic [WIN_W-1:0] high_reg;
  logic [WIN_W-1:0] high_next;

  // Pulse lines idle at their inactive level, so the majority level
  // over a window tells the sense
  always_comb begin
    win_next  = win_reg + {{(WIN_W-1){1'b0}}, 1'b1};
    high_next = high_reg + {{(WIN_W-1){1'b0}}, s2_reg};
    pol_next  = pol_reg;
    if (win_reg == '1) begin
      pol_next  = ~high_reg[WIN_W-1];
      high_next = '0;
    end
    pol_use  = manual_sel ? manual_pol : pol_reg;
    act_next = (s2_reg == pol_use);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      act_reg  <= 1'b0;
      pol_reg  <= 1'b1;
      win_reg  <= '0;
      high_reg <= '0;
    end else begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      act_reg  <= act_next;
      pol_reg  <= pol_next;
      win_reg  <= win_next;
      high_reg <= high_next;
    end
  end

  assign active   = act_reg;
  assign auto_pol = pol_reg;
endmodule
`default_nettype wire

//--- hw/cci_top.sv
// Capture control inputs: APB registers, clamp timer, coast, power-down, slicer
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cci_top
  import cci_pkg::*;
#(
  parameter int DET_W = DET_WIN_W
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESETN,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Control pins
  input  wire logic              HSYNC_PIN,
  input  wire logic              CLAMP_PIN,
  input  wire logic              SHARED_HOLD_OR_CLOCK_PIN,
  input  wire logic              POWER_DOWN_PIN,
  input  wire logic              EMBEDDED_SYNC_INPUT,
  // Clamp and clock generator controls
  output logic                   CLAMP_ACTIVE,
  output logic                   CLAMP_TO_MIDSCALE,
  output logic                   PLL_LEAD_PULSE,
  output logic                   COAST_HOLD,
  output logic                   EXT_CLOCK_SELECT,
  // Power and slicer
  output logic                   POWER_DOWN,
  output logic [SLICE_W-1:0]     SLICER_THRESHOLD,
  output logic                   SLICED_SYNC_OUTPUT
);
  logic [7:0]          clksel_reg;
  logic [7:0]          clksel_next;
  logic [7:0]          hspol_reg;
  logic [7:0]          hspol_next;
  logic [7:0]          clampc_reg;
  logic [7:0]          clampc_next;
  logic [7:0]          pwr_reg;
  logic [7:0]          pwr_next;
  logic [SLICE_W-1:0]  slice_reg;
  logic [SLICE_W-1:0]  slice_next;
  logic [CL_CNT_W-1:0] cldly_reg;
  logic [CL_CNT_W-1:0] cldly_next;
  logic [CL_CNT_W:0]   cldur_reg;
  logic [CL_CNT_W:0]   cldur_next;
  logic [31:0]         prdata_reg;
  logic [31:0]         prdata_next;
  logic                slverr_reg;
  logic                slverr_next;
  logic                wr_en;
  logic                setup;
  logic [31:0]         status;

  logic                hs_act;
  logic                hs_pol;
  logic                cl_pin_act;
  logic                cl_pol;
  logic                coast_act;
  logic                coast_pol;
  logic                pd_pin_act;
  logic                sog_act;
  logic                ext_clamp_en;

  logic                hs_prev_reg;
  logic                hs_lead;
  logic                hs_trail;
  cci_clamp_state_type cl_st_reg;
  cci_clamp_state_type cl_st_next;
  logic [CL_CNT_W-1:0] cl_cnt_reg;
  logic [CL_CNT_W-1:0] cl_cnt_next;
  logic                clamp_reg;
  logic                clamp_next;
  logic                lead_reg;
  logic                lead_next;
  logic                pd_reg;
  logic                pd_next;

  // ---------------------------------------------------------------
  // Pin conditioning
  // ---------------------------------------------------------------
  cci_pin_cond #(.WIN_W(DET_W)) u_hs (
    .clk        (CLK),
    .resetn     (RESETN),
    .pin_in     (HSYNC_PIN),
    .manual_sel (hspol_reg[HS_MAN_BIT]),
    .manual_pol (hspol_reg[HS_POL_BIT]),
    .active     (hs_act),
    .auto_pol   (hs_pol)
  );

  cci_pin_cond #(.WIN_W(DET_W)) u_clamp (
    .clk        (CLK),
    .resetn     (RESETN),
    .pin_in     (CLAMP_PIN),
    .manual_sel (clampc_reg[CL_MAN_BIT]),
    .manual_pol (clampc_reg[CL_POL_BIT]),
    .active     (cl_pin_act),
    .auto_pol   (cl_pol)
  );

  // Coast sees the shared pin whether or not the external clock is used
  cci_pin_cond #(.WIN_W(DET_W)) u_coast (
    .clk        (CLK),
    .resetn     (RESETN),
    .pin_in     (SHARED_HOLD_OR_CLOCK_PIN),
    .manual_sel (clampc_reg[CL_MAN_BIT]),
    .manual_pol (clampc_reg[CL_POL_BIT]),
    .active     (coast_act),
    .auto_pol   (coast_pol)
  );

  cci_pin_cond #(.WIN_W(DET_W)) u_pd (
    .clk        (CLK),
    .resetn     (RESETN),
    .pin_in     (POWER_DOWN_PIN),
    .manual_sel (1'b1),
    .manual_pol (pwr_reg[PD_POL_BIT]),
    .active     (pd_pin_act),
    .auto_pol   ()
  );

  cci_pin_cond #(.WIN_W(DET_W)) u_sog (
    .clk        (CLK),
    .resetn     (RESETN),
    .pin_in     (EMBEDDED_SYNC_INPUT),
    .manual_sel (1'b1),
    .manual_pol (1'b1),
    .active     (sog_act),
    .auto_pol   ()
  );

  // ---------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------
  assign wr_en  = PSEL & PENABLE & PWRITE;
  assign setup  = PSEL & ~PENABLE;
  assign status = {25'h0000000, clksel_reg[EXTERNAL_SAMPLE_CLOCK_BIT], coast_pol, cl_pol, hs_pol,
                   pd_reg, coast_act, clamp_reg};

  always_comb begin
    clksel_next = clksel_reg;
    hspol_next  = hspol_reg;
    clampc_next = clampc_reg;
    pwr_next    = pwr_reg;
    slice_next  = slice_reg;
    cldly_next  = cldly_reg;
    cldur_next  = cldur_reg;
    if (wr_en) begin
      case (PADDR)
        cci_addr(IDX_CLKSEL): clksel_next = PWDATA[7:0] & MASK_CLKSEL;
        cci_addr(IDX_HSPOL):  hspol_next  = PWDATA[7:0] & MASK_HSPOL;
        cci_addr(IDX_CLAMPC): clampc_next = PWDATA[7:0] & MASK_CLAMPC;
        cci_addr(IDX_PWR):    pwr_next    = PWDATA[7:0] & MASK_PWR;
        cci_addr(IDX_SLICE):  slice_next  = PWDATA[SLICE_W-1:0];
        cci_addr(IDX_CLDLY):  cldly_next  = PWDATA[CL_CNT_W-1:0];
        cci_addr(IDX_CLDUR):  cldur_next  = PWDATA[CL_CNT_W:0];
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup cycle, so the access needs no wait
  always_comb begin
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (setup) begin
      prdata_next = 32'h00000000;
      slverr_next = ~cci_hit(PADDR);
      case (PADDR)
        cci_addr(IDX_CLKSEL): prdata_next[7:0] = clksel_reg;
        cci_addr(IDX_HSPOL):  prdata_next[7:0] = hspol_reg;
        cci_addr(IDX_CLAMPC): prdata_next[7:0] = clampc_reg;
        cci_addr(IDX_PWR):    prdata_next[7:0] = pwr_reg;
        cci_addr(IDX_SLICE):  prdata_next[SLICE_W-1:0] = slice_reg;
        cci_addr(IDX_CLDLY):  prdata_next[CL_CNT_W-1:0] = cldly_reg;
        cci_addr(IDX_CLDUR):  prdata_next[CL_CNT_W:0] = cldur_reg;
        cci_addr(IDX_STAT):   prdata_next = status;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      clksel_reg <= RST_CLKSEL;
      hspol_reg  <= RST_HSPOL;
      clampc_reg <= RST_CLAMPC;
      pwr_reg    <= RST_PWR;
      slice_reg  <= RST_SLICE;
      cldly_reg  <= RST_CLDLY;
      cldur_reg  <= RST_CLDUR;
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else begin
      clksel_reg <= clksel_next;
      hspol_reg  <= hspol_next;
      clampc_reg <= clampc_next;
      pwr_reg    <= pwr_next;
      slice_reg  <= slice_next;
      cldly_reg  <= cldly_next;
      cldur_reg  <= cldur_next;
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_reg;
  assign PSLVERR = slverr_reg;

  // ---------------------------------------------------------------
  // Hsync edges and clamp timer
  // ---------------------------------------------------------------
  assign ext_clamp_en = clampc_reg[CL_EN_BIT];
  assign hs_lead      = hs_act & ~hs_prev_reg;
  assign hs_trail     = ~hs_act & hs_prev_reg;

  always_comb begin
    cl_st_next  = cl_st_reg;
    cl_cnt_next = cl_cnt_reg;
    case (cl_st_reg)
      CL_IDLE: begin
        if (hs_trail) begin
          cl_st_next  = CL_DELAY;
          cl_cnt_next = cldly_reg;
        end
      end
      CL_DELAY: begin
        if (cl_cnt_reg == '0) begin
          cl_st_next  = CL_HOLD;
          cl_cnt_next = cldur_reg[CL_CNT_W-1:0];
        end else begin
          cl_cnt_next = cl_cnt_reg - CL_ONE;
        end
      end
      CL_HOLD: begin
        if (cl_cnt_reg == '0) begin
          cl_st_next = CL_IDLE;
        end else begin
          cl_cnt_next = cl_cnt_reg - CL_ONE;
        end
      end
      default: cl_st_next = CL_IDLE;
    endcase
    // The internal timer sleeps while the pin owns the clamp
    if (ext_clamp_en) begin
      cl_st_next = CL_IDLE;
    end
  end

  always_comb begin
    clamp_next = ext_clamp_en ? cl_pin_act : (cl_st_next == CL_HOLD);
    lead_next  = hs_lead & ~coast_act;
    pd_next    = pwr_reg[PD_SW_BIT] | (pwr_reg[PD_MAN_BIT] & pd_pin_act);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hs_prev_reg <= 1'b0;
      cl_st_reg   <= CL_IDLE;
      cl_cnt_reg  <= '0;
      clamp_reg   <= 1'b0;
      lead_reg    <= 1'b0;
      pd_reg      <= 1'b0;
    end else begin
      hs_prev_reg <= hs_act;
      cl_st_reg   <= cl_st_next;
      cl_cnt_reg  <= cl_cnt_next;
      clamp_reg   <= clamp_next;
      lead_reg    <= lead_next;
      pd_reg      <= pd_next;
    end
  end

  assign CLAMP_ACTIVE       = clamp_reg;
  assign CLAMP_TO_MIDSCALE  = cldur_reg[MID_BIT];
  assign PLL_LEAD_PULSE     = lead_reg;
  assign COAST_HOLD         = coast_act;
  assign EXT_CLOCK_SELECT   = clksel_reg[EXTERNAL_SAMPLE_CLOCK_BIT];
  assign POWER_DOWN         = pd_reg;
  assign SLICER_THRESHOLD   = slice_reg;
  assign SLICED_SYNC_OUTPUT = sog_act;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_trail_start;
    !ext_clamp_en && hs_trail && cl_st_reg == CL_IDLE;
  endsequence
  sequence s_delay_done;
    !ext_clamp_en && cl_st_reg == CL_DELAY && cl_cnt_reg == '0;
  endsequence

  AST_CLAMP_PIN_GATED: assert property (!ext_clamp_en && cl_st_reg == CL_IDLE |=> !CLAMP_ACTIVE)
    else $error("clamp active without timer or pin enable");
  AST_CLAMP_START: assert property (s_trail_start |=> cl_st_reg == CL_DELAY && cl_cnt_reg == $past(cldly_reg))
    else $error("clamp delay not started at trailing edge");
  AST_CLAMP_HOLD: assert property (s_delay_done |=> cl_st_reg == CL_HOLD && CLAMP_ACTIVE)
    else $error("clamp interval not entered after delay");
  AST_EXT_CLAMP: assert property ((ext_clamp_en && clampc_reg[CL_MAN_BIT]
                                   && CLAMP_PIN == clampc_reg[CL_POL_BIT])[*3] ##1 ext_clamp_en |=> CLAMP_ACTIVE)
    else $error("external clamp not followed");
  AST_COAST: assert property ((clampc_reg[CL_MAN_BIT]
                               && SHARED_HOLD_OR_CLOCK_PIN == clampc_reg[CL_POL_BIT])[*3] |=> COAST_HOLD)
    else $error("coast not asserted from shared pin");
  AST_COAST_NO_TRACK: assert property (COAST_HOLD |=> !PLL_LEAD_PULSE)
    else $error("leading edge passed during coast");
  AST_LEAD_EDGE: assert property (hs_lead && !coast_act |=> PLL_LEAD_PULSE ##1 !PLL_LEAD_PULSE)
    else $error("leading edge pulse missing or long");
  AST_RESET_VALUES: assert property (@(posedge CLK) disable iff (1'b0)
                                     !RESETN |-> clampc_reg == RST_CLAMPC)
    else $error("clamp and coast control reset value wrong");
  AST_SLICE_DEFAULT: assert property (@(posedge CLK) disable iff (1'b0)
                                      !RESETN |-> SLICER_THRESHOLD == RST_SLICE)
    else $error("slicer threshold default wrong");
  AST_EXTERNAL_SAMPLE_CLOCK_WR: assert property (wr_en && PADDR == cci_addr(IDX_CLKSEL)
                                  && PWDATA[EXTERNAL_SAMPLE_CLOCK_BIT] |=> EXT_CLOCK_SELECT)
    else $error("external clock select not taken");
  AST_PD_PIN: assert property (pwr_reg[PD_MAN_BIT] && pd_pin_act |=> POWER_DOWN)
    else $error("power-down pin ignored under manual control");
  AST_PD_OFF: assert property (!pwr_reg[PD_SW_BIT] && !pwr_reg[PD_MAN_BIT] |=> !POWER_DOWN)
    else $error("power-down without cause");
  AST_SLICED: assert property ((EMBEDDED_SYNC_INPUT)[*3] |=> SLICED_SYNC_OUTPUT)
    else $error("sliced sync inverted or late");
endmodule
`default_nettype wire

//--- tb/cci_src_model.sv
// Source model: hsync lines, back-porch clamp pulse, coast and power-down pins
`timescale 1ns/100ps
`default_nettype none
module cci_src_model #(
  parameter int LINE = 40,
  parameter int HS_W = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Commands from the bench
  input  wire logic clamp_inv,
  input  wire logic coast_req,
  input  wire logic pd_req,
  // Pins toward the block
  output logic      hsync_pin,
  output logic      clamp_pin,
  output logic      hold_pin,
  output logic      pd_pin,
  output logic      sync_pin
);
  int cnt;
  // Idle pins sit low, as a pull-down or a tie to ground would hold them, except the clamp pin, which idles high while clamp_inv is set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt       <= 0;
      hsync_pin <= 1'b0;
      clamp_pin <= 1'b0;
      hold_pin  <= 1'b0;
      pd_pin    <= 1'b0;
      sync_pin  <= 1'b0;
    end else begin
      cnt       <= (cnt == LINE - 1) ? 0 : cnt + 1;
      hsync_pin <= (cnt < HS_W);
      // Clamp pulse only in the back porch, well after the trailing edge
      clamp_pin <= clamp_inv ^ (cnt >= 2 * HS_W && cnt < 2 * HS_W + 3);
      hold_pin  <= coast_req;
      pd_pin    <= pd_req;
      sync_pin  <= (cnt < HS_W);
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the capture control inputs
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cci_pkg::*;
  localparam int LINE = 40;
  typedef struct packed {
    logic        wr;
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        err;
  } cci_row_type;
  logic              CLK = 1'b0, RESETN = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0]       PWDATA = '0, PRDATA, rd;
  logic              PREADY, PSLVERR, er, HSYNC_PIN, CLAMP_PIN, HOLD_PIN, PD_PIN, SYNC_PIN;
  logic              CLAMP_ACTIVE, CLAMP_TO_MIDSCALE, PLL_LEAD_PULSE, COAST_HOLD, EXT_CLOCK_SELECT, POWER_DOWN;
  logic              SLICED_SYNC_OUTPUT, clamp_inv = 1'b0, coast_req = 1'b0, pd_req = 1'b0;
  logic [SLICE_W-1:0] SLICER_THRESHOLD;
  int                errors = 0, cmp_count = 0, ncl, nld, nsl, d1, d2;
  cci_row_type rows [15] = '{
    '{1'b0, 8'h03, 32'h0, 32'h000, 1'b0}, '{1'b0, 8'h12, 32'h0, 32'h000, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h040, 1'b0}, '{1'b0, 8'h1E, 32'h0, 32'h000, 1'b0},
    '{1'b0, 8'h40, 32'h0, 32'h00F, 1'b0}, '{1'b0, 8'h41, 32'h0, 32'h010, 1'b0},
    '{1'b0, 8'h42, 32'h0, 32'h010, 1'b0}, '{1'b0, 8'h43, 32'h0, 32'h038, 1'b0},
    '{1'b1, 8'h03, 32'hFFFFFFFF, 32'h004, 1'b0}, '{1'b1, 8'h12, 32'hFFFFFFFF, 32'h030, 1'b0},
    '{1'b1, 8'h18, 32'hFFFFFFFF, 32'h0D0, 1'b0}, '{1'b1, 8'h1E, 32'hFFFFFFFF, 32'h01C, 1'b0},
    '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h01F, 1'b0}, '{1'b1, 8'h42, 32'hFFFFFFFF, 32'h1FF, 1'b0},
    '{1'b1, 8'h44, 32'h000000FF, 32'h000, 1'b1}};
  // Power-down rows: register value, pin level, expected output
  logic [9:0] pd_rows [7] = '{{8'h00, 1'b1, 1'b0}, {8'h08, 1'b0, 1'b1}, {8'h14, 1'b1, 1'b1},
    {8'h14, 1'b0, 1'b0}, {8'h10, 1'b0, 1'b1}, {8'h10, 1'b1, 1'b0}, {8'h04, 1'b1, 1'b0}};

  always #50 CLK = ~CLK;

  cci_top #(.DET_W(4)) uut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HSYNC_PIN(HSYNC_PIN), .CLAMP_PIN(CLAMP_PIN), .SHARED_HOLD_OR_CLOCK_PIN(HOLD_PIN),
    .POWER_DOWN_PIN(PD_PIN), .EMBEDDED_SYNC_INPUT(SYNC_PIN), .CLAMP_ACTIVE(CLAMP_ACTIVE),
    .CLAMP_TO_MIDSCALE(CLAMP_TO_MIDSCALE), .PLL_LEAD_PULSE(PLL_LEAD_PULSE), .COAST_HOLD(COAST_HOLD),
    .EXT_CLOCK_SELECT(EXT_CLOCK_SELECT), .POWER_DOWN(POWER_DOWN), .SLICER_THRESHOLD(SLICER_THRESHOLD),
    .SLICED_SYNC_OUTPUT(SLICED_SYNC_OUTPUT));
  cci_src_model #(.LINE(LINE), .HS_W(4)) src (.clk(CLK), .resetn(RESETN), .clamp_inv(clamp_inv),
    .coast_req(coast_req), .pd_req(pd_req), .hsync_pin(HSYNC_PIN), .clamp_pin(CLAMP_PIN),
    .hold_pin(HOLD_PIN), .pd_pin(PD_PIN), .sync_pin(SYNC_PIN));

  // ---------------------------------------------------------------
  // Bus, compare and measurement tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Signals move right after an edge and hold until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {2'b00, idx, 2'b00};
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Counts over exactly one line period after the settings have settled
  task automatic line_cnt();
    ncl = 0;
    nld = 0;
    nsl = 0;
    repeat (3 * LINE) @(posedge CLK);
    repeat (LINE) begin
      @(posedge CLK);
      ncl += int'(CLAMP_ACTIVE === 1'b1);
      nld += int'(PLL_LEAD_PULSE === 1'b1);
      nsl += int'(SLICED_SYNC_OUTPUT === 1'b1);
    end
  endtask
  // Cycles from the trailing hsync edge at the pin to the clamp start
  task automatic clamp_delay(output int d);
    @(negedge HSYNC_PIN);
    d = 0;
    do begin
      @(posedge CLK);
      d++;
    end while (CLAMP_ACTIVE !== 1'b1 && d < 200);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    // A real falling edge, so the asynchronous resets fire at time zero
    RESETN <= 1'b0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        apb(1'b1, rows[i].idx, rows[i].wd);
        chk("wr_err", 32'(rows[i].err), 32'(er));
      end
      apb(1'b0, rows[i].idx, 32'h0);
      chk("rd_data", rows[i].exp, rd);
      chk("rd_err", 32'(rows[i].err), 32'(er));
    end
    chk("ext_clock", 32'h1, 32'(EXT_CLOCK_SELECT));
    chk("slicer", 32'h1F, 32'(SLICER_THRESHOLD));
    chk("midscale", 32'h1, 32'(CLAMP_TO_MIDSCALE));
    apb(1'b1, 8'h03, 32'h0);
    repeat (2) @(posedge CLK);
    chk("ext_clock", 32'h0, 32'(EXT_CLOCK_SELECT));
    foreach (pd_rows[i]) begin
      apb(1'b1, 8'h1E, {24'h0, pd_rows[i][9:2]});
      pd_req <= pd_rows[i][1];
      repeat (6) @(posedge CLK);
      chk("power_down", 32'(pd_rows[i][0]), 32'(POWER_DOWN));
    end
    pd_req <= 1'b0;
    apb(1'b1, 8'h1E, 32'h0);
    apb(1'b1, 8'h18, 32'hC0);
    apb(1'b1, 8'h41, 32'h03);
    apb(1'b1, 8'h42, 32'h05);
    line_cnt();
    chk("int_clamp", 32'd6, 32'(ncl));
    chk("lead", 32'd1, 32'(nld));
    chk("sliced", 32'd4, 32'(nsl));
    chk("midscale", 32'h0, 32'(CLAMP_TO_MIDSCALE));
    clamp_delay(d1);
    apb(1'b1, 8'h41, 32'h07);
    clamp_delay(d2);
    chk("delay_step", 32'd4, 32'(d2 - d1));
    apb(1'b1, 8'h18, 32'hD0);
    line_cnt();
    chk("ext_clamp", 32'd3, 32'(ncl));
    clamp_inv <= 1'b1;
    apb(1'b1, 8'h18, 32'h90);
    line_cnt();
    chk("ext_clamp_low", 32'd3, 32'(ncl));
    apb(1'b1, 8'h18, 32'h10);
    line_cnt();
    chk("ext_clamp_auto", 32'd3, 32'(ncl));
    apb(1'b1, 8'h18, 32'hC0);
    apb(1'b1, 8'h03, 32'h04);
    coast_req <= 1'b1;
    line_cnt();
    chk("coast_lead", 32'd0, 32'(nld));
    chk("coast_hold", 32'h1, 32'(COAST_HOLD));
    coast_req <= 1'b0;
    apb(1'b1, 8'h18, 32'h80);
    line_cnt();
    chk("coast_low", 32'd0, 32'(nld));
    apb(1'b1, 8'h18, 32'hC0);
    line_cnt();
    chk("coast_off", 32'd1, 32'(nld));
    RESETN <= 1'b0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    apb(1'b0, 8'h18, 32'h0);
    chk("rd_data", 32'h040, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("rd_data", 32'h00F, rd);
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge CLK);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
